// ---- design/cml_top.sv ----
/*
  Clock unit tail: display frame-rate and boost-update dividers, routing of
  the two clock-output pins, and the configuration lock over the protected
  clock registers, all behind a classic Wishbone slave.
  Assumes the low-frequency A clock and the prescaled display clock arrive as
  pins far slower than clk_i, and that the protected registers live in a
  neighbouring block that takes writes only through prot_wr_o.
*/
`timescale 1ns/1ps
`default_nettype none

module cml_top
  import cml_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire cml_pkg::cml_wb_req_t wb_req_i,
  output cml_pkg::cml_wb_rsp_t wb_rsp_o,
  // Protected register bank elsewhere in the unit
  output cml_pkg::cml_prot_wr_t prot_wr_o,
  input wire logic [cml_pkg::CML_DW-1:0] prot_rdat_i,
  // Slow clock pins and display clock gate
  input wire logic low_freq_a_clock_i,
  input wire logic disp_pre_clock_i,
  input wire logic disp_clock_en_i,
  // Divided enables and boost control
  output logic disp_tick_o,
  output logic boost_tick_o,
  output logic boost_enable_o,
  // Clock outputs, same-domain sources
  input wire logic [1:0] clk_out_src_i,
  output logic [1:0] pin_site_zero_o,
  output logic [1:0] pin_site_zero_oe_o,
  output logic [1:0] pin_site_one_o,
  output logic [1:0] pin_site_one_oe_o,
  // Lock state
  output logic locked_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into an old word
  function automatic logic [CML_DW-1:0] cml_merge(
    input logic [CML_DW-1:0] old_v,
    input logic [CML_DW-1:0] new_v,
    input logic [CML_SW-1:0] sel
  );
    logic [CML_DW-1:0] res;
    res = old_v;
    for (int i = 0; i < CML_SW; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Terminal count for division by two to the power of the field
  function automatic logic [CML_CNT_W-1:0] cml_pow2_tc(
    input logic [CML_BUDIV_W-1:0] exp_v
  );
    logic [CML_CNT_W:0] one_hot;
    one_hot = {{CML_CNT_W{1'b0}}, 1'b1} << exp_v;
    return CML_CNT_W'(one_hot - 1'b1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [CML_FRDIV_W-1:0] frame_rate_divider_r;
  logic [CML_FRDIV_W-1:0] frame_rate_divider_nxt;
  logic boost_enable_r;
  logic boost_enable_nxt;
  logic [CML_BUDIV_W-1:0] boost_update_divider_r;
  logic [CML_BUDIV_W-1:0] boost_update_divider_nxt;
  logic first_clock_output_pin_enable_r;
  logic first_clock_output_pin_enable_nxt;
  logic second_clock_output_pin_enable_r;
  logic second_clock_output_pin_enable_nxt;
  cml_site_t site_r;
  cml_site_t site_nxt;
  logic lock_r;
  logic lock_nxt;

  // Bus state
  logic ack_r;
  logic ack_nxt;
  logic [CML_DW-1:0] rdat_r;
  logic [CML_DW-1:0] rdat_nxt;
  cml_prot_wr_t prot_wr_r;
  cml_prot_wr_t prot_wr_nxt;

  // Outputs
  logic [1:0] site0_r;
  logic [1:0] site0_nxt;
  logic [1:0] site0_oe_r;
  logic [1:0] site0_oe_nxt;
  logic [1:0] site1_r;
  logic [1:0] site1_nxt;
  logic [1:0] site1_oe_r;
  logic [1:0] site1_oe_nxt;

  // Decode and helpers
  logic req;
  logic wr_now;
  logic hit_disp;
  logic hit_route;
  logic hit_lock;
  logic hit_prot;
  logic [CML_DW-1:0] disp_word;
  logic [CML_DW-1:0] route_word;
  logic [CML_DW-1:0] lock_word;
  logic [CML_DW-1:0] wr_word;
  logic [CML_KEY_W-1:0] key_word;
  logic [1:0] pen;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and current register images, reserved bits read zero
  assign req = wb_req_i.cyc && wb_req_i.stb;
  // A write lands on the edge where the master sees ack
  assign wr_now = req && wb_req_i.we && ack_r;
  assign hit_disp = (wb_req_i.adr == CML_OFS_DISP_CTRL);
  assign hit_route = (wb_req_i.adr == CML_OFS_ROUTE);
  assign hit_lock = (wb_req_i.adr == CML_OFS_LOCK);
  assign hit_prot = (wb_req_i.adr < CML_OFS_PROT_END);

  always_comb
  begin
    disp_word = '0;
    disp_word[CML_FRDIV_LSB +: CML_FRDIV_W] = frame_rate_divider_r;
    disp_word[CML_BOOSTEN_BIT] = boost_enable_r;
    disp_word[CML_BUDIV_LSB +: CML_BUDIV_W] = boost_update_divider_r;
    route_word = '0;
    route_word[CML_PEN0_BIT] = first_clock_output_pin_enable_r;
    route_word[CML_PEN1_BIT] = second_clock_output_pin_enable_r;
    route_word[CML_LOC_BIT] = (site_r == CML_PIN_SITE_ONE);
    lock_word = '0;
    lock_word[CML_LOCKED_BIT] = lock_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request, dropped the next cycle
  always_comb
  begin
    ack_nxt = req && !ack_r;
    rdat_nxt = rdat_r;
    prot_wr_nxt = '0;
    if (req && !ack_r)
    begin
      // Unmapped offsets answer with zero and ignore writes
      rdat_nxt = '0;
      if (hit_disp)
      begin
        rdat_nxt = disp_word;
      end
      else if (hit_route)
      begin
        rdat_nxt = route_word;
      end
      else if (hit_lock)
      begin
        rdat_nxt = lock_word;
      end
      else if (hit_prot)
      begin
        rdat_nxt = prot_rdat_i;
      end
    end
    // Protected writes pass only while unlocked
    if (wr_now && hit_prot && !lock_r)
    begin
      prot_wr_nxt.stb = 1'b1;
      prot_wr_nxt.adr = wb_req_i.adr;
      prot_wr_nxt.sel = wb_req_i.sel;
      prot_wr_nxt.dat = wb_req_i.dat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      prot_wr_r <= '0;
    end
    else
    begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      prot_wr_r <= prot_wr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are simply not stored
  always_comb
  begin
    frame_rate_divider_nxt = frame_rate_divider_r;
    boost_enable_nxt = boost_enable_r;
    boost_update_divider_nxt = boost_update_divider_r;
    first_clock_output_pin_enable_nxt = first_clock_output_pin_enable_r;
    second_clock_output_pin_enable_nxt = second_clock_output_pin_enable_r;
    site_nxt = site_r;
    lock_nxt = lock_r;
    wr_word = '0;
    key_word = '0;
    if (wr_now && hit_disp)
    begin
      wr_word = cml_merge(disp_word, wb_req_i.dat, wb_req_i.sel);
      // Changing this while the display clock runs is the software's hazard
      frame_rate_divider_nxt = wr_word[CML_FRDIV_LSB +: CML_FRDIV_W];
      boost_enable_nxt = wr_word[CML_BOOSTEN_BIT];
      boost_update_divider_nxt = wr_word[CML_BUDIV_LSB +: CML_BUDIV_W];
    end
    else if (wr_now && hit_route)
    begin
      wr_word = cml_merge(route_word, wb_req_i.dat, wb_req_i.sel);
      first_clock_output_pin_enable_nxt = wr_word[CML_PEN0_BIT];
      second_clock_output_pin_enable_nxt = wr_word[CML_PEN1_BIT];
      site_nxt = wr_word[CML_LOC_BIT] ? CML_PIN_SITE_ONE : CML_PIN_SITE_ZERO;
    end
    else if (wr_now && hit_lock && (wb_req_i.sel[1:0] != 2'h0))
    begin
      // Unwritten key lanes count as zero, since the key is never stored
      wr_word = cml_merge('0, wb_req_i.dat, wb_req_i.sel);
      key_word = wr_word[CML_KEY_W-1:0];
      lock_nxt = (key_word != CML_UNLOCK_KEY);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_rate_divider_r <= CML_FRDIV_RST;
      boost_enable_r <= CML_BOOSTEN_RST;
      boost_update_divider_r <= CML_BUDIV_RST;
      first_clock_output_pin_enable_r <= CML_PEN_RST;
      second_clock_output_pin_enable_r <= CML_PEN_RST;
      site_r <= CML_PIN_SITE_ZERO;
      lock_r <= CML_LOCK_RST;
    end
    else
    begin
      frame_rate_divider_r <= frame_rate_divider_nxt;
      boost_enable_r <= boost_enable_nxt;
      boost_update_divider_r <= boost_update_divider_nxt;
      first_clock_output_pin_enable_r <= first_clock_output_pin_enable_nxt;
      second_clock_output_pin_enable_r <= second_clock_output_pin_enable_nxt;
      site_r <= site_nxt;
      lock_r <= lock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers; boost ticks run only while boost is on
  cml_edge_div u_frame_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(disp_pre_clock_i),
    .run_i(disp_clock_en_i),
    .tc_i(CML_CNT_W'(frame_rate_divider_r)),
    .tick_o(disp_tick_o)
  );

  cml_edge_div u_boost_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(low_freq_a_clock_i),
    .run_i(boost_enable_r),
    .tc_i(cml_pow2_tc(boost_update_divider_r)),
    .tick_o(boost_tick_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock-output pins: drive only the chosen site, only when enabled
  assign pen = {second_clock_output_pin_enable_r, first_clock_output_pin_enable_r};

  always_comb
  begin
    site0_nxt = '0;
    site1_nxt = '0;
    site0_oe_nxt = '0;
    site1_oe_nxt = '0;
    unique case (site_r)
      CML_PIN_SITE_ZERO:
      begin
        site0_nxt = clk_out_src_i & pen;
        site0_oe_nxt = pen;
      end
      CML_PIN_SITE_ONE:
      begin
        site1_nxt = clk_out_src_i & pen;
        site1_oe_nxt = pen;
      end
    endcase
  end

  // The output stage costs a cycle of skew, accepted for clean pin timing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      site0_r <= '0;
      site0_oe_r <= '0;
      site1_r <= '0;
      site1_oe_r <= '0;
    end
    else
    begin
      site0_r <= site0_nxt;
      site0_oe_r <= site0_oe_nxt;
      site1_r <= site1_nxt;
      site1_oe_r <= site1_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring, all from flip-flops
  assign wb_rsp_o.ack = ack_r;
  assign wb_rsp_o.dat = rdat_r;
  assign prot_wr_o = prot_wr_r;
  assign boost_enable_o = boost_enable_r;
  assign locked_o = lock_r;
  assign pin_site_zero_o = site0_r;
  assign pin_site_zero_oe_o = site0_oe_r;
  assign pin_site_one_o = site1_r;
  assign pin_site_one_oe_o = site1_oe_r;

endmodule
`default_nettype wire

// ---- design/cml_pkg.sv ----
/*
  Shared constants and types for the clock unit display-divider, pin-routing
  and configuration-lock block.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package cml_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths
  localparam int unsigned CML_AW = 12;
  localparam int unsigned CML_DW = 32;
  localparam int unsigned CML_SW = 4;

  // Register byte offsets
  localparam logic [CML_AW-1:0] CML_OFS_DISP_CTRL = 12'h07C;
  localparam logic [CML_AW-1:0] CML_OFS_ROUTE = 12'h080;
  localparam logic [CML_AW-1:0] CML_OFS_LOCK = 12'h084;
  // Protected registers of the unit lie below this offset
  localparam logic [CML_AW-1:0] CML_OFS_PROT_END = 12'h07C;

  ////////////////////////////////////////////////////////////////////////////
  // Display clock divider control fields
  localparam int unsigned CML_FRDIV_LSB = 0;
  localparam int unsigned CML_FRDIV_W = 3;
  localparam int unsigned CML_BOOSTEN_BIT = 3;
  localparam int unsigned CML_BUDIV_LSB = 4;
  localparam int unsigned CML_BUDIV_W = 3;
  localparam logic [CML_FRDIV_W-1:0] CML_FRDIV_RST = 3'h0;
  localparam logic [CML_BUDIV_W-1:0] CML_BUDIV_RST = 3'h2;
  localparam logic CML_BOOSTEN_RST = 1'b0;

  // Routing fields
  localparam int unsigned CML_PEN0_BIT = 0;
  localparam int unsigned CML_PEN1_BIT = 1;
  localparam int unsigned CML_LOC_BIT = 2;
  localparam logic CML_PEN_RST = 1'b0;

  // Lock fields
  localparam int unsigned CML_KEY_W = 16;
  localparam logic [CML_KEY_W-1:0] CML_UNLOCK_KEY = 16'h580E;
  localparam int unsigned CML_LOCKED_BIT = 0;
  localparam logic CML_LOCK_RST = 1'b0;

  // Divider counter width, enough for division by 128
  localparam int unsigned CML_CNT_W = 7;

  // Pin site choice
  typedef enum logic {
    CML_PIN_SITE_ZERO,
    CML_PIN_SITE_ONE
  } cml_site_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [CML_AW-1:0] adr;
    logic [CML_SW-1:0] sel;
    logic [CML_DW-1:0] dat;
  } cml_wb_req_t;

  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [CML_DW-1:0] dat;
  } cml_wb_rsp_t;

  // Write toward the protected registers elsewhere in the unit
  typedef struct packed {
    logic stb;
    logic [CML_AW-1:0] adr;
    logic [CML_SW-1:0] sel;
    logic [CML_DW-1:0] dat;
  } cml_prot_wr_t;

endpackage

// ---- design/cml_edge_div.sv ----
/*
  Pin-clock edge divider: brings a slow clock pin into the bus clock domain
  through three flip-flops and emits a one-cycle enable pulse on every
  (tc+1)-th rising edge of it.
  Assumes the pin clock is far slower than clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module cml_edge_div
  import cml_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Slow pin clock and terminal count
  input wire logic pin_i,
  input wire logic run_i,
  input wire logic [cml_pkg::CML_CNT_W-1:0] tc_i,
  // Divided enable pulse
  output logic tick_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic level_r;
  logic level_nxt;
  logic [CML_CNT_W-1:0] cnt_r;
  logic [CML_CNT_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic rise;

  // Stage 2 and 3 must agree before the level changes; stage 1 feeds only stage 2
  always_comb
  begin
    sync_nxt = {sync_r[1:0], pin_i};
    level_nxt = level_r;
    if (sync_r[1] == sync_r[2])
    begin
      level_nxt = sync_r[2];
    end
    rise = level_nxt && !level_r;
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run_i)
    begin
      cnt_nxt = '0; // Held idle so a new enable starts a full period
    end
    else if (rise)
    begin
      if (cnt_r >= tc_i)
      begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_r <= '0;
      level_r <= 1'b0;
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      sync_r <= sync_nxt;
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule
`default_nettype wire

// ---- tb/cml_top_asserts.sv ----
/*
  Concurrent checks on the ports of cml_top, bound to every instance.
  Assumes single-cycle Wishbone requests held until ack is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module cml_top_asserts
  import cml_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and protected bank
  input wire cml_pkg::cml_wb_req_t wb_req_i,
  input wire cml_pkg::cml_wb_rsp_t wb_rsp_o,
  input wire cml_pkg::cml_prot_wr_t prot_wr_o,
  input wire logic [cml_pkg::CML_DW-1:0] prot_rdat_i,
  // Dividers, pins and lock
  input wire logic disp_clock_en_i,
  input wire logic disp_tick_o,
  input wire logic boost_tick_o,
  input wire logic boost_enable_o,
  input wire logic [1:0] pin_site_zero_oe_o,
  input wire logic [1:0] pin_site_one_oe_o,
  input wire logic locked_o
);
  ////////////////////////////////////////////////////////
  // One domain, so clock and reset are shared by all checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Transfer steps: request seen, then the edge where ack is sampled
  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence s_wr(logic [CML_AW-1:0] a);
    wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == a;
  endsequence
  sequence s_rd;
    wb_rsp_o.ack && !wb_req_i.we;
  endsequence
  // A key write carrying both key byte lanes
  sequence s_key_wr;
    s_wr(CML_OFS_LOCK) ##0 wb_req_i.sel[1:0] == 2'b11;
  endsequence

  ////////////////////////////////////////////////////////
  AST_ACK_ONE: assert property (s_req |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
    else $error("ack not a single pulse one cycle after request");
  AST_LOCK_SET: assert property (s_wr(CML_OFS_LOCK) ##0 (|wb_req_i.sel[1:0])
    ##0 wb_req_i.dat[15:0] != CML_UNLOCK_KEY |=> locked_o)
    else $error("wrong key did not lock");
  AST_UNLOCK: assert property (s_key_wr ##0 wb_req_i.dat[15:0] == CML_UNLOCK_KEY
    |=> !locked_o)
    else $error("unlock key did not unlock");
  AST_LOCK_READ: assert property (s_rd ##0 wb_req_i.adr == CML_OFS_LOCK
    |-> wb_rsp_o.dat == 32'(locked_o))
    else $error("lock read is not the lock state alone");
  AST_PROT_FWD: assert property (s_req ##0 wb_req_i.we && wb_req_i.adr < CML_OFS_PROT_END
    ##1 wb_rsp_o.ack |=> prot_wr_o.stb == !$past(locked_o)
    && (!prot_wr_o.stb || prot_wr_o.dat == $past(wb_req_i.dat)))
    else $error("protected write forwarding disagrees with lock");
  AST_PROT_RD: assert property (s_rd ##0 wb_req_i.adr < CML_OFS_PROT_END
    |-> wb_rsp_o.dat == $past(prot_rdat_i))
    else $error("protected read data lost");
  AST_BOOST_EN: assert property (s_wr(CML_OFS_DISP_CTRL) ##0 wb_req_i.sel[0]
    |=> boost_enable_o == $past(wb_req_i.dat[3]))
    else $error("boost enable not taken from bit 3");
  AST_BOOST_GATE: assert property (!boost_enable_o [*2] |-> !boost_tick_o)
    else $error("boost tick while boost is off");
  AST_DISP_GATE: assert property (!disp_clock_en_i [*4] |-> !disp_tick_o)
    else $error("display tick while its clock is off");
  AST_SITE_ONE: assert property (pin_site_zero_oe_o == 2'b00 || pin_site_one_oe_o == 2'b00)
    else $error("both pin sites driven");
endmodule

bind cml_top cml_top_asserts u_chk (
  .clk_i,
  .rst_i,
  .wb_req_i,
  .wb_rsp_o,
  .prot_wr_o,
  .prot_rdat_i,
  .disp_clock_en_i,
  .disp_tick_o,
  .boost_tick_o,
  .boost_enable_o,
  .pin_site_zero_oe_o,
  .pin_site_one_oe_o,
  .locked_o
);
`default_nettype wire

// ---- tb/cml_top_tb.sv ----
/*
  Self-checking bench for cml_top: register model, lock, pin routing and
  divider tick counts over fixed windows.
  Assumes the design answers each Wishbone request within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module cml_top_tb;
  import cml_pkg::*;
  ////////////////////////////////////////////////////////
  logic clk_i;
  logic rst_i;
  cml_wb_req_t req;
  cml_wb_rsp_t rsp;
  cml_prot_wr_t pwr;
  logic [CML_DW-1:0] prot_rdat;
  logic [7:0] cnt;
  logic disp_en;
  logic disp_tick;
  logic boost_tick;
  logic boost_en;
  logic [1:0] src;
  logic [1:0] en;
  logic [1:0] z_d, z_oe, o_d, o_oe;
  logic locked;
  logic [31:0] q;
  int n_fail, n_checks, n_prot, n_disp, n_boost, seed, disp_m, w, b0, d0, p0;
  // Register model and expected protected writes as {sel, adr, dat}
  int m_disp, m_route, m_lock;
  logic [47:0] pq[$];

  cml_top u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .prot_wr_o(pwr),
    .prot_rdat_i(prot_rdat),
    .low_freq_a_clock_i(cnt[2]),
    .disp_pre_clock_i(cnt[2]),
    .disp_clock_en_i(disp_en),
    .disp_tick_o(disp_tick),
    .boost_tick_o(boost_tick),
    .boost_enable_o(boost_en),
    .clk_out_src_i(src),
    .pin_site_zero_o(z_d),
    .pin_site_zero_oe_o(z_oe),
    .pin_site_one_o(o_d),
    .pin_site_one_oe_o(o_oe),
    .locked_o(locked)
  );

  // Clock; slow pins are a counter bit, one rising edge every eight cycles
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    cnt <= cnt + 8'h01;
  // Pulses counted mid-cycle so the main sequence never races them
  always @(negedge clk_i)
  begin
    if (boost_tick === 1'b1) n_boost++;
    if (disp_tick === 1'b1) n_disp++;
    if (pwr.stb === 1'b1)
    begin
      n_prot++;
      n_checks++;
      // Every forwarded write must be the model's next one
      if (pq.size() == 0 || pq[0] !== {pwr.sel, pwr.adr, pwr.dat})
      begin
        n_fail++;
        $display("BAD prot_wr exp %h got %h", pq.size() > 0 ? pq[0] : 48'h0,
                 {pwr.sel, pwr.adr, pwr.dat});
      end
      if (pq.size() > 0)
        void'(pq.pop_front());
    end
  end

  ////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] sel,
                    input logic [31:0] d);
    int k;
    logic [31:0] bm;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sel, dat: d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (rsp.ack !== 1'b1 && k < 16);
    q = rsp.dat;
    // Model takes the write at the same edge as the design
    if (we && rsp.ack === 1'b1)
    begin
      bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      if (a == CML_OFS_DISP_CTRL)
        m_disp = ((m_disp & ~bm) | (d & bm)) & 32'h0000_007f;
      else if (a == CML_OFS_ROUTE)
        m_route = ((m_route & ~bm) | (d & bm)) & 32'h0000_0007;
      else if (a == CML_OFS_LOCK && sel[1:0] != 2'b00)
        m_lock = 32'((d & bm & 32'h0000_ffff) != 32'(CML_UNLOCK_KEY));
      else if (a < CML_OFS_PROT_END && m_lock == 0)
        pq.push_back({sel, a, d});
    end
    req <= '0;
    if (k >= 16)
    begin
      n_fail++;
      $display("BAD ack exp 1 got 0");
      results();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 4'hf, 32'h0000_0000);
    chk(nm, e, q);
    chk({nm, "_model"}, mdl(a), q);
  endtask

  // Read value that the register model predicts
  function automatic logic [31:0] mdl(input logic [11:0] a);
    if (a == CML_OFS_DISP_CTRL)
      return m_disp;
    if (a == CML_OFS_ROUTE)
      return m_route;
    if (a == CML_OFS_LOCK)
      return m_lock;
    if (a < CML_OFS_PROT_END)
      return prot_rdat;
    return 32'h0000_0000;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h4e7e_b4d1;
    {n_fail, n_checks, n_prot, n_disp, n_boost} = '0;
    m_disp = 32'h0000_0020;
    m_route = 0;
    m_lock = 0;
    req = '0;
    prot_rdat = '0;
    cnt = '0;
    disp_en = 1'b0;
    src = 2'b00;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CML_OFS_DISP_CTRL, 32'h0000_0020, "disp");
    rd(CML_OFS_ROUTE, 32'h0000_0000, "route");
    rd(CML_OFS_LOCK, 32'h0000_0000, "lock");
    rd(12'h088, 32'h0000_0000, "unmapped");
    // Every routing setting, pin sources random but steady
    for (int r = 0; r < 8; r++)
    begin
      src <= 2'($random(seed));
      wb(1'b1, CML_OFS_ROUTE, 4'hf, 32'(r));
      repeat (3) @(posedge clk_i);
      en = 2'(r);
      chk("oe0", r[2] ? 32'h0 : 32'(en), 32'(z_oe));
      chk("oe1", r[2] ? 32'(en) : 32'h0, 32'(o_oe));
      chk("pin", 32'(src & en), 32'(r[2] ? o_d : z_d));
      rd(CML_OFS_ROUTE, 32'(r), "route");
    end
    // Random divider settings, written while the display clock is off
    repeat (6)
    begin
      disp_m = $random(seed) & 32'h7f;
      wb(1'b1, CML_OFS_DISP_CTRL, 4'hf, disp_m);
      // The write lands on the ack edge, so look one edge later
      @(posedge clk_i);
      chk("boost_en", 32'(disp_m[3]), 32'(boost_en));
      rd(CML_OFS_DISP_CTRL, disp_m, "disp");
    end
    // Lock by zero, by the key with its high lane missing, by a random key
    for (int i = 0; i < 3; i++)
    begin
      prot_rdat <= $random(seed);
      p0 = n_prot;
      wb(1'b1, CML_OFS_LOCK, i == 1 ? 4'h1 : 4'hf,
         i == 0 ? 32'h0 : (i == 1 ? 32'h580e : ($random(seed) & 32'hfff0)));
      rd(CML_OFS_LOCK, 32'h1, "lock");
      chk("locked", 32'h1, 32'(locked));
      wb(1'b1, 12'h000, 4'hf, $random(seed));
      rd(12'h078, prot_rdat, "prot_rd");
      chk("prot_wr", 32'(p0), 32'(n_prot));
    end
    wb(1'b1, CML_OFS_LOCK, 4'h3, 32'h0000_580e);
    rd(CML_OFS_LOCK, 32'h0, "lock");
    p0 = n_prot;
    wb(1'b1, 12'h040, 4'hf, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("prot_wr", 32'(p0 + 1), 32'(n_prot));
    // Both dividers at every value; window holds whole periods of each
    for (int i = 0; i < 8; i++)
    begin
      disp_en <= 1'b0;
      wb(1'b1, CML_OFS_DISP_CTRL, 4'hf, 32'(i * 17 + 8));
      repeat (4) @(posedge clk_i);
      disp_en <= 1'b1;
      w = 8 * (1 << i) * (i + 1);
      repeat (w + 40) @(posedge clk_i);
      b0 = n_boost;
      d0 = n_disp;
      repeat (w) @(posedge clk_i);
      chk("boost_ticks", 32'(i + 1), 32'(n_boost - b0));
      chk("disp_ticks", 32'(1 << i), 32'(n_disp - d0));
    end
    // Mid-run reset while locked and routed: everything back to reset values
    wb(1'b1, CML_OFS_LOCK, 4'hf, 32'h0000_0000);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    m_disp = 32'h0000_0020;
    m_route = 0;
    m_lock = 0;
    rd(CML_OFS_DISP_CTRL, 32'h0000_0020, "disp_rst");
    rd(CML_OFS_ROUTE, 32'h0000_0000, "route_rst");
    rd(CML_OFS_LOCK, 32'h0000_0000, "lock_rst");
    chk("boost_rst", 32'h0, 32'(boost_en));
    chk("oe_rst", 32'h0, 32'({z_oe, o_oe}));
    chk("prot_q", 32'h0, 32'(pq.size()));
    results();
  end
endmodule
`default_nettype wire
